/* hdl/diq_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz pclk and a 32-bit APB data path
`ifndef DIQ_DEFINES_SVH
`define DIQ_DEFINES_SVH

`define DIQ_A_CTRL 8'h00
`define DIQ_A_STATUS 8'h04
`define DIQ_A_MASK 8'h08
`define DIQ_A_QLO 8'h0c
`define DIQ_A_QHI 8'h10
`define DIQ_A_QSTATE 8'h14
`define DIQ_A_INPUT 8'h18
`define DIQ_A_CUR 8'h1c
`define DIQ_A_MAX 8'h20
`define DIQ_A_MIN 8'h24
`define DIQ_A_BASE 8'h28
`define DIQ_A_CLOCK 8'h2c
`define DIQ_A_BCOUNT 8'h30
`define DIQ_A_BINFO 8'h34
`define DIQ_A_BFIELD 8'h38
`define DIQ_A_BSTAMP 8'h3c

`define DIQ_C_QMODE 1:0
`define DIQ_C_LATCH_EN 2
`define DIQ_C_LATCH_CLR 3
`define DIQ_C_FUNC0 5:4
`define DIQ_C_FUNC1 7:6
`define DIQ_C_RELAY_Q 9:8
`define DIQ_C_RELAY_MAN 11:10
`define DIQ_CTRL_MASK 32'h0000_0ff7

`define DIQ_S_READING 0
`define DIQ_S_OVERFLOW 1
`define DIQ_S_QUAL 2
`define DIQ_S_INPUT 3

`define DIQ_CTRL_RST 32'h0000_0000
`define DIQ_MASK_RST 4'h0
`define DIQ_QLO_RST 32'h0000_0000
`define DIQ_QHI_RST 32'h0000_0000
`define DIQ_MAX_RST 32'h8000_0000
`define DIQ_MIN_RST 32'h7fff_ffff

`define DIQ_BUF_DEPTH 128
`define DIQ_CLK_NS 10
`define DIQ_WIN_MS 10
`define DIQ_MID_MS 5
`define DIQ_WIN_CYC ((`DIQ_WIN_MS * 1000000) / `DIQ_CLK_NS)
`define DIQ_MID_CYC ((`DIQ_MID_MS * 1000000) / `DIQ_CLK_NS)
`define DIQ_MS_CYC (1000000 / `DIQ_CLK_NS)

`endif

/* hdl/diq_input_chan.sv */
// one digital input: sampled level, rise detect, function decode
// assumes sample is a one-cycle strobe from the window timer
`timescale 1ns/1ns
module diq_input_chan (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic sample,
	input wire logic din,
	input wire diq_pkg::diq_func_type func,
	output logic level,
	output logic rise,
	output logic ev_maxmin,
	output logic ev_tare,
	output logic ev_latch
);
	logic level_r;
	logic level_nxt;

	always_comb begin
		level_nxt = sample ? din : level_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_r <= 1'b0;
		end else if (ce) begin
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
	// low in one sample, high in the next
	assign rise = sample & din & ~level_r; // [R19]
	assign ev_maxmin = rise && func == diq_pkg::DIQ_FN_MAXMIN; // [R11]
	assign ev_tare = rise && func == diq_pkg::DIQ_FN_TARE; // [R12]
	assign ev_latch = rise && func == diq_pkg::DIQ_FN_LATCH; // [R13]

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_manual_quiet: assert property (func == diq_pkg::DIQ_FN_MANUAL |-> // [R9]
		!(ev_maxmin || ev_tare || ev_latch)) else $error("manual input caused an event");
	a_rise_edge: assert property (rise && ce |=> level_r && !rise) // [R19]
		else $error("rise without a new high sample");
endmodule

/* hdl/diq_pkg.sv */
// types shared by the input qualifier block
// assumes nothing beyond the defines header
package diq_pkg;
	typedef enum logic [1:0] {
		DIQ_FN_MANUAL,
		DIQ_FN_MAXMIN,
		DIQ_FN_TARE,
		DIQ_FN_LATCH
	} diq_func_type;

	typedef enum logic [1:0] {
		DIQ_Q_BETWEEN,
		DIQ_Q_OUTSIDE,
		DIQ_Q_ABS_BETWEEN,
		DIQ_Q_ABS_OUTSIDE
	} diq_qmode_type;
endpackage

/* hdl/diq_top.sv */
// digital input qualifier and time-stamped measurement buffer, APB slave
// assumes field_in holds the window's reading in the last window cycle
//
// Function
// (R1) keep newest 128 readings, drop oldest
// (R2) readout pops entries, emptying the buffer
// (R3) each entry carries a millisecond timestamp
// (R4) reader drains faster than buffer fills
// (R5) qualifier flags threshold condition continuously
// (R6) latched qualifier holds until latch reset
// (R7) four comparison forms, plain or magnitude
// (R8) two inputs, each with own function
// (R9) manual input only records its level
// (R10) input sample paired with same-window reading
// (R11) rise on max/min input reloads holds
// (R12) rise on tare input stores baseline
// (R13) rise on latch-clear input clears latch
// (R14) level query: bit0 input1, bit1 input2
// (R15) inputs sampled every 10 ms window
// (R16) sample taken at 5 ms midpoint
// (R17) level query returns latest sample only
// (R18) qualifier relay closed while condition met
// (R19) rise means low then high sample
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "diq_defines.svh"
module diq_top #(
	parameter int WIN_CYC = `DIQ_WIN_CYC,
	parameter int MID_CYC = `DIQ_MID_CYC,
	parameter int MS_CYC = `DIQ_MS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] din,
	input wire logic [31:0] field_in,
	output logic win_start,
	output logic [1:0] relay_close,
	output logic irq
);
	localparam int DEPTH = `DIQ_BUF_DEPTH;

	logic [65:0] mem [0:DEPTH-1];
	logic [31:0] ctrl_r, ctrl_nxt, qlo_r, qlo_nxt, qhi_r, qhi_nxt;
	logic [31:0] cur_r, cur_nxt, max_r, max_nxt, min_r, min_nxt, base_r, base_nxt;
	logic [31:0] ms_r, ms_nxt, tick_r, tick_nxt, cnt_r, cnt_nxt;
	logic [31:0] prdata_r, prdata_nxt, rd_mux;
	logic [3:0] st_r, st_nxt, mask_r, mask_nxt, st_set;
	logic [6:0] rp_r, rp_nxt, wp_r, wp_nxt;
	logic [7:0] bcnt_r, bcnt_nxt;
	logic [1:0] relay_r, relay_nxt, lvl, rise;
	logic [1:0] ev_mm, ev_tr, ev_lt;
	logic latched_r, latched_nxt, qind_r, qind_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic acc, done, hit, wr, rd, sample, win_end, ms_tick, push, pop, drop;
	logic cond, latch_en, latch_clr, in_band;
	logic signed [31:0] val, lo_s, hi_s;
	diq_pkg::diq_qmode_type qmode;
	diq_pkg::diq_func_type func [0:1];

	// window timer
	assign win_start = ce && cnt_r == 32'h0;
	assign sample = cnt_r == 32'(MID_CYC); // [R16]
	assign win_end = cnt_r == 32'(WIN_CYC - 1);
	assign ms_tick = tick_r == 32'(MS_CYC - 1);

	// APB handshake with one wait state so read data come from flops
	assign acc = psel & penable;
	assign done = acc & pready_r;
	assign pready = pready_r & ce;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign wr = done & pwrite & hit;
	assign rd = done & ~pwrite & hit;

	assign qmode = diq_pkg::diq_qmode_type'(ctrl_r[`DIQ_C_QMODE]);
	assign latch_en = ctrl_r[`DIQ_C_LATCH_EN];
	assign func[0] = diq_pkg::diq_func_type'(ctrl_r[`DIQ_C_FUNC0]);
	assign func[1] = diq_pkg::diq_func_type'(ctrl_r[`DIQ_C_FUNC1]);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_in
			diq_input_chan u_chan ( // [R8]
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.sample(sample), // [R15]
				.din(din[gi]),
				.func(func[gi]),
				.level(lvl[gi]),
				.rise(rise[gi]),
				.ev_maxmin(ev_mm[gi]),
				.ev_tare(ev_tr[gi]),
				.ev_latch(ev_lt[gi])
			);
		end
	endgenerate

	// threshold check on the latest reading
	always_comb begin
		lo_s = signed'(qlo_r);
		hi_s = signed'(qhi_r);
		val = signed'(cur_r);
		if (qmode == diq_pkg::DIQ_Q_ABS_BETWEEN || qmode == diq_pkg::DIQ_Q_ABS_OUTSIDE) begin
			val = val < 0 ? -val : val; // [R7]
		end
		in_band = val >= lo_s && val <= hi_s;
		unique case (qmode)
			diq_pkg::DIQ_Q_BETWEEN, diq_pkg::DIQ_Q_ABS_BETWEEN: cond = in_band; // [R7]
			diq_pkg::DIQ_Q_OUTSIDE, diq_pkg::DIQ_Q_ABS_OUTSIDE: cond = !in_band; // [R5]
		endcase
	end

	// register decode and read mux
	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0;
		unique case (paddr)
			`DIQ_A_CTRL: rd_mux = ctrl_r;
			`DIQ_A_STATUS: rd_mux = {28'h0, st_r};
			`DIQ_A_MASK: rd_mux = {28'h0, mask_r};
			`DIQ_A_QLO: rd_mux = qlo_r;
			`DIQ_A_QHI: rd_mux = qhi_r;
			`DIQ_A_QSTATE: rd_mux = {29'h0, qind_r, latched_r, cond};
			`DIQ_A_INPUT: rd_mux = {30'h0, lvl}; // [R14] [R17]
			`DIQ_A_CUR: rd_mux = cur_r;
			`DIQ_A_MAX: rd_mux = max_r;
			`DIQ_A_MIN: rd_mux = min_r;
			`DIQ_A_BASE: rd_mux = base_r;
			`DIQ_A_CLOCK: rd_mux = ms_r;
			`DIQ_A_BCOUNT: rd_mux = {24'h0, bcnt_r};
			`DIQ_A_BINFO: rd_mux = {30'h0, mem[rp_r][65:64]};
			`DIQ_A_BFIELD: rd_mux = mem[rp_r][31:0];
			`DIQ_A_BSTAMP: rd_mux = mem[rp_r][63:32];
			default: hit = 1'b0;
		endcase
		if (bcnt_r == 8'h0 && (paddr == `DIQ_A_BINFO || paddr == `DIQ_A_BFIELD
			|| paddr == `DIQ_A_BSTAMP)) begin
			rd_mux = 32'h0;
		end
	end

	// buffer pointers: push at window end, pop on stamp read
	assign push = ce & win_end;
	assign pop = rd && paddr == `DIQ_A_BSTAMP && bcnt_r != 8'h0; // [R2]
	// full buffer: oldest entry gives way to the newest
	assign drop = push && !pop && bcnt_r == 8'(DEPTH); // [R1]
	assign latch_clr = (|ev_lt) | (wr && paddr == `DIQ_A_CTRL && pwdata[`DIQ_C_LATCH_CLR]);

	always_comb begin
		st_set = 4'h0;
		st_set[`DIQ_S_READING] = push;
		st_set[`DIQ_S_OVERFLOW] = drop;
		st_set[`DIQ_S_QUAL] = qind_nxt & ~qind_r;
		st_set[`DIQ_S_INPUT] = |rise;
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		qlo_nxt = qlo_r;
		qhi_nxt = qhi_r;
		ms_nxt = ms_r;
		tick_nxt = ms_tick ? 32'h0 : tick_r + 32'h1;
		cnt_nxt = win_end ? 32'h0 : cnt_r + 32'h1; // [R15]
		cur_nxt = cur_r;
		max_nxt = max_r;
		min_nxt = min_r;
		base_nxt = base_r;
		pready_nxt = acc & ~pready_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (acc && !pready_r) begin
			prdata_nxt = pwrite ? 32'h0 : rd_mux;
			pslverr_nxt = ~hit;
		end
		if (ms_tick) begin
			ms_nxt = ms_r + 32'h1; // [R3]
		end
		if (wr) begin
			unique case (paddr)
				`DIQ_A_CTRL: ctrl_nxt = pwdata & `DIQ_CTRL_MASK;
				`DIQ_A_MASK: mask_nxt = pwdata[3:0];
				`DIQ_A_QLO: qlo_nxt = pwdata;
				`DIQ_A_QHI: qhi_nxt = pwdata;
				`DIQ_A_CLOCK: begin
					ms_nxt = pwdata;
					tick_nxt = 32'h0;
				end
				default: ;
			endcase
		end
		// new reading closes the window; holds track it
		if (win_end) begin
			cur_nxt = field_in;
			if (signed'(field_in) > signed'(max_r)) begin
				max_nxt = field_in;
			end
			if (signed'(field_in) < signed'(min_r)) begin
				min_nxt = field_in;
			end
		end
		if (|ev_mm) begin
			max_nxt = cur_r; // [R11]
			min_nxt = cur_r; // [R11]
		end
		if (|ev_tr) begin
			base_nxt = cur_r; // [R12]
		end
		// set wins over clear on the latch and on status bits
		latched_nxt = latch_en & (cond | (latched_r & ~latch_clr)); // [R6] [R13]
		qind_nxt = latch_en ? latched_nxt : cond; // [R5]
		// relay i: qualifier indication or its manual state
		for (int i = 0; i < 2; i++) begin
			relay_nxt[i] = ctrl_r[8 + i] ? qind_r : ctrl_r[10 + i]; // [R18]
		end
		st_nxt = st_r;
		if (rd && paddr == `DIQ_A_STATUS) begin
			st_nxt = st_r & ~prdata_r[3:0];
		end
		st_nxt = st_nxt | st_set;
		rp_nxt = rp_r + 7'(pop | drop); // [R1]
		wp_nxt = wp_r + 7'(push);
		bcnt_nxt = bcnt_r + 8'(push) - 8'(pop) - 8'(drop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `DIQ_CTRL_RST;
			mask_r <= `DIQ_MASK_RST;
			qlo_r <= `DIQ_QLO_RST;
			qhi_r <= `DIQ_QHI_RST;
			ms_r <= 32'h0;
			tick_r <= 32'h0;
			cnt_r <= 32'h0;
			cur_r <= 32'h0;
			max_r <= `DIQ_MAX_RST;
			min_r <= `DIQ_MIN_RST;
			base_r <= 32'h0;
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
			latched_r <= 1'b0;
			qind_r <= 1'b0;
			relay_r <= 2'h0;
			st_r <= 4'h0;
			rp_r <= 7'h0;
			wp_r <= 7'h0;
			bcnt_r <= 8'h0;
		end else if (ce) begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			qlo_r <= qlo_nxt;
			qhi_r <= qhi_nxt;
			ms_r <= ms_nxt;
			tick_r <= tick_nxt;
			cnt_r <= cnt_nxt;
			cur_r <= cur_nxt;
			max_r <= max_nxt;
			min_r <= min_nxt;
			base_r <= base_nxt;
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			latched_r <= latched_nxt;
			qind_r <= qind_nxt;
			relay_r <= relay_nxt;
			st_r <= st_nxt;
			rp_r <= rp_nxt;
			wp_r <= wp_nxt;
			bcnt_r <= bcnt_nxt;
		end
	end

	// entry: levels sampled mid-window, stamp, reading of the same window
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wp_r] <= {lvl, ms_r, field_in}; // [R10] [R3]
		end
	end

	assign relay_close = relay_r;
	// level interrupt while any unmasked sticky bit is set
	assign irq = |(st_r & mask_r);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_buf_bound: assert property (bcnt_r <= 8'(DEPTH)) // [R1]
		else $error("buffer count above depth");
	a_full_drop: assert property (push && !pop && bcnt_r == 8'(DEPTH) |=> // [R1]
		bcnt_r == 8'(DEPTH) && st_r[`DIQ_S_OVERFLOW]) else $error("full buffer not rolled");
	a_pop_drains: assert property (ce && pop && !push |=> // [R2]
		bcnt_r == $past(bcnt_r) - 8'h1) else $error("stamp read did not pop");
	a_stamp_tick: assert property (ce && ms_tick && !wr |=> ms_r == $past(ms_r) + 32'h1) // [R3]
		else $error("millisecond counter did not advance");
	a_latch_hold: assert property (ce && latch_en && latched_r && !latch_clr // [R6]
		&& !(wr && paddr == `DIQ_A_CTRL) |=> latched_r) else $error("latch dropped");
	a_latch_clear: assert property (ce && (|ev_lt) && !cond && !(wr && paddr == `DIQ_A_CTRL) // [R13]
		|=> !latched_r) else $error("latch not cleared");
	a_tare_load: assert property (ce && (|ev_tr) |=> base_r == $past(cur_r)) // [R12]
		else $error("tare did not take reading");
	a_maxmin_load: assert property (ce && (|ev_mm) |=> max_r == $past(cur_r) // [R11]
		&& min_r == $past(cur_r)) else $error("holds not reloaded");
	a_sample_mid: assert property (ce && win_start ##1 (ce && cnt_r == 32'h1)
		|-> !sample) else $error("sample at window start"); // [R16]
	a_window_wrap: assert property (ce && win_end |=> cnt_r == 32'h0) // [R15]
		else $error("window did not restart");
	a_level_query: assert property (ce && acc && !pready_r && !pwrite && paddr == `DIQ_A_INPUT // [R14]
		|=> prdata_r[1:0] == $past(lvl) && prdata_r[31:2] == 30'h0) else $error("bad input query");
	a_relay_qual: assert property (ce && ctrl_r[8] && !wr |=> relay_r[0] == $past(qind_r)) // [R18]
		else $error("relay not following qualifier");

	// bus answer, freeze, pairing and sticky status
	a_apb_wait: assert property (ce && acc && !pready_r |=> pready_r)
		else $error("access phase not answered");
	a_error_flag: assert property (ce && acc && !pready_r |=> pslverr_r == !$past(hit))
		else $error("error flag does not match decode");
	a_freeze_state: assert property (!ce |=> cnt_r == $past(cnt_r) && ms_r == $past(ms_r)
		&& bcnt_r == $past(bcnt_r)) else $error("state moved while enable low");
	a_qual_direct: assert property (ce && !latch_en |=> qind_r == $past(cond)) // [R5]
		else $error("indication not following condition");
	a_level_take: assert property (ce && sample |=> lvl == $past(din)) // [R15]
		else $error("input level not taken at sample");
	a_entry_pair: assert property (push |=> mem[$past(wp_r)] == // [R10]
		{$past(lvl), $past(ms_r), $past(field_in)}) else $error("entry fields not paired");
	a_status_sticky: assert property (ce && st_r[`DIQ_S_READING] && !rd |=>
		st_r[`DIQ_S_READING]) else $error("status bit lost without read");
	a_relay_manual: assert property (ce && !ctrl_r[9] |=> relay_r[1] == $past(ctrl_r[11]))
		else $error("manual relay state not applied");

	c_push_full: cover property (drop);
	c_pop_entry: cover property (pop);
	c_latch_event: cover property (latched_r && (|ev_lt));
	c_tare_event: cover property (|ev_tr);
	c_qual_relay: cover property (relay_r[0] && ctrl_r[8]);
endmodule

/* testbench/digital_input_qualifier_buffer_tb.sv */
// self-checking bench: inputs, qualifier, holds and buffer over apb
// assumes short windows: 100 cycles, midpoint 50, 10 cycles per ms
`timescale 1ns/1ns
`include "diq_defines.svh"
module digital_input_qualifier_buffer_tb;
	localparam int WIN = 100;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, win_start, irq, e, ce;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, fld, field_in, q, prev;
	logic [1:0] lvl, din, relay_close;
	logic [1:0] lv[5];
	logic [31:0] fv[5];
	int errors, compares, seed, k, m;
	int qf[4] = '{-150, 50, 150, 300};

	diq_top #(.WIN_CYC(WIN), .MID_CYC(50), .MS_CYC(10)) dut_u (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .din(din),
		.field_in(field_in), .win_start(win_start), .relay_close(relay_close), .irq(irq));
	diq_equip #(.WIN(WIN)) equip_u (.pclk(pclk), .presetn(presetn), .win_start(win_start),
		.lvl(lvl), .fld(fld), .din(din), .field_in(field_in));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic win();
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (win_start !== 1'b1 && n < 300);
	endtask

	function automatic logic qexp(input int m, input int f);
		int a;
		a = f < 0 ? -f : f;
		case (m)
			0: return f > 100 && f < 200;
			1: return f < 100 || f > 200;
			2: return a > 100 && a < 200;
			default: return a < 100 || a > 200;
		endcase
	endfunction

	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (40000) @(posedge pclk);
		errors++;
		results();
	end

	initial begin
		seed = 32'h3f25;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lvl = 2'h0;
		fld = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped error", 32'h1, e);
		apb(1'b1, 8'h44, 32'hffff_ffff);
		chk("unmapped write error", 32'h1, e);
		$display("test bus done");
		win();
		// drop the entry of the first window
		apb(1'b0, `DIQ_A_BSTAMP, 32'h0);
		prev = q;
		for (k = 0; k < 5; k++) begin
			lv[k] = 2'($random(seed));
			fv[k] = $random(seed);
			lvl <= lv[k];
			fld <= fv[k];
			// change level after the midpoint
			repeat (68) @(posedge pclk);
			lvl <= ~lv[k];
			win();
			apb(1'b0, `DIQ_A_INPUT, 32'h0);
			chk("input levels", {30'h0, lv[k]}, q);
		end
		apb(1'b0, `DIQ_A_BASE, 32'h0);
		chk("base under manual", 32'h0, q);
		apb(1'b0, `DIQ_A_BCOUNT, 32'h0);
		chk("buffer count", 32'h5, q);
		for (k = 0; k < 5; k++) begin
			apb(1'b0, `DIQ_A_BINFO, 32'h0);
			chk("entry levels", {30'h0, lv[k]}, q);
			apb(1'b0, `DIQ_A_BFIELD, 32'h0);
			chk("entry reading", fv[k], q);
			apb(1'b0, `DIQ_A_BSTAMP, 32'h0);
			chk("stamp step", 32'ha, q - prev);
			prev = q;
		end
		apb(1'b0, `DIQ_A_BCOUNT, 32'h0);
		chk("count after readout", 32'h0, q);
		$display("test stream done");
		apb(1'b1, `DIQ_A_MASK, 32'h2);
		for (k = 0; k < 130; k++) begin
			fld <= k;
			win();
		end
		apb(1'b0, `DIQ_A_BCOUNT, 32'h0);
		chk("full count", 32'd128, q);
		chk("irq on overflow", 32'h1, irq);
		apb(1'b0, `DIQ_A_BFIELD, 32'h0);
		chk("oldest kept", 32'h2, q);
		apb(1'b0, `DIQ_A_STATUS, 32'h0);
		chk("overflow status", 32'h1, q[1]);
		repeat (2) @(posedge pclk);
		chk("irq after clear", 32'h0, irq);
		apb(1'b1, `DIQ_A_MASK, 32'h0);
		$display("test overflow done");
		apb(1'b1, `DIQ_A_QLO, 32'd100);
		apb(1'b1, `DIQ_A_QHI, 32'd200);
		for (m = 0; m < 4; m++) begin
			apb(1'b1, `DIQ_A_CTRL, 32'h100 | m);
			for (k = 0; k < 4; k++) begin
				fld <= qf[k];
				win();
				apb(1'b0, `DIQ_A_QSTATE, 32'h0);
				chk("qualifier", qexp(m, qf[k]), q[0]);
				chk("relay", qexp(m, qf[k]), relay_close[0]);
			end
		end
		$display("test qualifier done");
		apb(1'b1, `DIQ_A_CTRL, 32'h134);
		lvl <= 2'h0;
		fld <= 32'd150;
		win();
		fld <= 32'd300;
		win();
		apb(1'b0, `DIQ_A_QSTATE, 32'h0);
		chk("latched hold", 32'h6, q[2:0]);
		lvl <= 2'h1;
		win();
		apb(1'b0, `DIQ_A_QSTATE, 32'h0);
		chk("latch cleared", 32'h0, q[2:0]);
		chk("relay open", 32'h0, relay_close[0]);
		fld <= 32'd150;
		win();
		fld <= 32'd300;
		win();
		apb(1'b0, `DIQ_A_QSTATE, 32'h0);
		chk("no second rise", 32'h6, q[2:0]);
		apb(1'b1, `DIQ_A_CTRL, 32'h13c);
		apb(1'b0, `DIQ_A_QSTATE, 32'h0);
		chk("write clear", 32'h0, q[2:0]);
		$display("test latch done");
		apb(1'b1, `DIQ_A_CTRL, 32'h890);
		lvl <= 2'h0;
		fld <= 32'd1000;
		win();
		fld <= 32'd7;
		win();
		lvl <= 2'h3;
		win();
		apb(1'b0, `DIQ_A_MAX, 32'h0);
		chk("max reload", 32'd7, q);
		apb(1'b0, `DIQ_A_MIN, 32'h0);
		chk("min reload", 32'd7, q);
		apb(1'b0, `DIQ_A_BASE, 32'h0);
		chk("tare baseline", 32'd7, q);
		chk("relay manual", 32'h2, relay_close);
		$display("test holds done");
		// loaded stamp must not move while the enable is low
		apb(1'b1, `DIQ_A_CLOCK, 32'h1234_5678);
		ce <= 1'b0;
		repeat (200) @(posedge pclk);
		ce <= 1'b1;
		apb(1'b0, `DIQ_A_CLOCK, 32'h0);
		chk("clock frozen", 32'h1234_5678, q);
		$display("test freeze done");
		results();
	end
endmodule

/* testbench/diq_equip.sv */
// external equipment: drives both inputs and the field reading
// assumes win_start marks window count 0 of the device
`timescale 1ns/1ns
module diq_equip #(
	parameter int WIN = 100
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic win_start,
	input wire logic [1:0] lvl,
	input wire logic [31:0] fld,
	output logic [1:0] din,
	output logic [31:0] field_in
);
	int cnt;
	// reading valid only in the last window cycle
	assign field_in = (cnt == WIN - 1) ? fld : ~fld;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			din <= 2'h0;
		end else begin
			cnt <= win_start ? 1 : cnt + 1;
			din <= lvl;
		end
	end
endmodule
